// File: shared/pcvb_pkg.sv
// Package of offsets, field positions, reset values and modes for the PWM channel block
package pcvb_pkg;
   // Register byte addresses
   localparam logic [7:0] ADDR_TSC     = 8'h00; // Timer status/control
   localparam logic [7:0] ADDR_CNT     = 8'h04; // Counter, read only
   localparam logic [7:0] ADDR_MOD_HI  = 8'h08; // Modulo high byte
   localparam logic [7:0] ADDR_MOD_LO  = 8'h0c; // Modulo low byte
   localparam logic [7:0] ADDR_CH_CTL  = 8'h10; // Channel mode
   localparam logic [7:0] ADDR_CHV_HI  = 8'h14; // Channel value high byte
   localparam logic [7:0] ADDR_CHV_LO  = 8'h18; // Channel value low byte
   localparam logic [7:0] ADDR_STATUS  = 8'h1c; // Block state, read only
   // Field positions in the status/control register
   localparam int TSC_CS_LSB   = 3;             // Clock source select, two bits
   localparam int TSC_CENTER_ALIGNED_PWM_BIT = 5;             // Center-aligned mode
   // Field positions in the status register
   localparam int ST_CHV_PEND  = 0;             // Channel word complete, waiting
   localparam int ST_CHV_HALF  = 1;             // One channel byte written
   localparam int ST_MOD_HALF  = 2;             // One modulo byte written
   localparam int ST_OUT       = 3;             // Channel output level
   localparam int ST_UP        = 4;             // Counting up
   // Reset values
   localparam logic [7:0]  TSC_RST  = 8'h00;
   localparam logic [15:0] MOD_RST  = 16'h0000;
   localparam logic [15:0] CHV_RST  = 16'h0000;
   localparam logic [15:0] CNT_FREE = 16'hffff;  // Free-running top count
   // Channel modes
   typedef enum logic [1:0] {
      PCVB_CH_OFF  = 2'b00,                     // No output function outside center-aligned mode
      PCVB_CH_OC   = 2'b01,                     // Output compare, toggle on match
      PCVB_CH_EDGE_ALIGNED_PWM = 2'b10,                     // Edge-aligned PWM
      PCVB_CH_RSV  = 2'b11                      // Treated as off
   } pcvb_ch_mode_t;
   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : pcvb_pkg

// File: src/pcvb_byte_pair.sv
// Two-byte write coherency buffer: collects high and low bytes into one word
`timescale 1ns/1ps
module pcvb_byte_pair #(
   parameter int W = 16
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         ce,
   input  wire logic         wr_hi,
   input  wire logic         wr_lo,
   input  wire logic [7:0]   wbyte,
   input  wire logic         clr,
   input  wire logic         take,
   output logic [W-1:0]      word_r,
   output logic              half_r,
   output logic              full_r
);
   logic hi_seen_r;   // High byte captured
   logic lo_seen_r;   // Low byte captured

   // Byte capture; either byte order is accepted
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         word_r <= '0;
      end else if (ce && wr_hi) begin
         word_r[W-1:8] <= wbyte[W-9:0];
      end else if (ce && wr_lo) begin
         word_r[7:0] <= wbyte;
      end
   end

   // Pairing flags; a clear discards any half-written word
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hi_seen_r <= 1'b0;
         lo_seen_r <= 1'b0;
         full_r    <= 1'b0;
      end else if (ce) begin
         if (clr) begin
            hi_seen_r <= 1'b0;
            lo_seen_r <= 1'b0;
            full_r    <= 1'b0;
         end else if ((wr_hi && lo_seen_r) || (wr_lo && hi_seen_r)) begin
            // Second byte completes the word
            hi_seen_r <= 1'b0;
            lo_seen_r <= 1'b0;
            full_r    <= 1'b1;
         end else begin
            if (wr_hi) hi_seen_r <= 1'b1;
            if (wr_lo) lo_seen_r <= 1'b1;
            // Completion wins over a take in the same cycle
            if (take) full_r <= 1'b0;
         end
      end
   end

   assign half_r = hi_seen_r | lo_seen_r;
endmodule : pcvb_byte_pair

// File: src/pcvb_channel.sv
// PWM channel with double-buffered compare value, counter and AXI4-Lite registers
//
// Function
// - Edge PWM: load value at modulo-1 to modulo
// - Free-running counter: load at 0xfffe to 0xffff
// - Center PWM: load value at modulo-1 to modulo
// - Center PWM: value equals modulo gives 100%
// - Center PWM: value modulo-1 gives near 100%
// - Zero to nonzero waits for new period
// - Nonzero to zero finishes period with old duty
// - Control write in debug clears modulo half-write
// - Control write clears channel value half-write
// - Center: up to modulo, down to zero
// - Debug mode suspends all counting
// - Output compare: load at next counter change
`timescale 1ns/1ps
module pcvb_channel
   import pcvb_pkg::*;
(
   input  wire logic          aclk,
   input  wire logic          aresetn,
   input  wire logic          clk_en,
   input  wire logic          background_debug_mode,
   // AXI4-Lite slave
   input  wire logic [7:0]    s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   input  wire logic [7:0]    s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready,
   // Channel pin
   output logic               ch_out
);
   import pcvb_pkg::*;

   // Bus-side state
   logic [7:0]    aw_addr_r;        // Held write address
   logic          aw_have_r;        // Write address taken
   logic [31:0]   w_data_r;         // Held write data
   logic          w_strb0_r;        // Low byte lane enabled
   logic          w_have_r;         // Write data taken
   logic          wr_go;            // Both halves present, execute write
   logic          wr_hit;           // Address maps to a register
   // Registers
   logic [7:0]    timer_status_control_r;
   logic [1:0]    ch_mode_r;        // Channel mode field
   logic [15:0]   counter_modulo_word_r;
   logic [15:0]   channel_compare_word_r; // Active compare value
   logic [15:0]   cnt_r;            // Timer counter
   logic          up_r;             // Count direction, 1 is up
   logic          out_r;            // Channel output
   // Decoded control
   logic [1:0]    clock_source_select;
   logic          center_aligned_pwm;
   logic          edge_aligned_pwm;
   logic          tick;             // Counter steps this cycle
   logic [15:0]   top;              // Effective top count
   logic          xfer_pt;          // Counter steps from top-1 to top
   // Write strobes into the pair buffers
   logic          wr_tsc;
   logic          wr_mod_hi;
   logic          wr_mod_lo;
   logic          wr_chv_hi;
   logic          wr_chv_lo;
   logic          mod_clr;
   logic          chv_take;
   logic [15:0]   mod_buf;
   logic          mod_half;
   logic          mod_full;
   logic [15:0]   chv_buf;
   logic          chv_half;
   logic          chv_full;
   logic [31:0]   rd_val;           // Read mux
   logic          rd_hit;

   assign clock_source_select = timer_status_control_r[TSC_CS_LSB +: 2];
   assign center_aligned_pwm  = timer_status_control_r[TSC_CENTER_ALIGNED_PWM_BIT];
   assign edge_aligned_pwm    = !center_aligned_pwm && (ch_mode_r == PCVB_CH_EDGE_ALIGNED_PWM);

   // Counting only with a clock source and outside debug mode
   assign tick = clk_en && (clock_source_select != 2'b00)
                 && !background_debug_mode;

   // Modulo 0 or 0xffff makes the counter free-running
   assign top = ((counter_modulo_word_r == 16'h0000) || (counter_modulo_word_r == CNT_FREE))
                ? CNT_FREE : counter_modulo_word_r;

   // Upward step from top-1 to top
   assign xfer_pt = tick && up_r && (cnt_r == top - 16'h0001);

   // ---------------- AXI4-Lite write path ----------------
   // Ready while the slot is empty and no response is pending;
   // low while frozen, so no item is handed over that would be lost
   assign s_axi_awready = clk_en && !aw_have_r && !s_axi_bvalid;
   assign s_axi_wready  = clk_en && !w_have_r && !s_axi_bvalid;
   assign wr_go         = clk_en && aw_have_r && w_have_r && !s_axi_bvalid;

   // Address and data may arrive in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r  <= 32'h0000_0000;
         w_strb0_r <= 1'b0;
      end else if (clk_en) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_have_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r  <= 1'b1;
            w_data_r  <= s_axi_wdata;
            w_strb0_r <= s_axi_wstrb[0];
         end else if (wr_go) begin
            w_have_r <= 1'b0;
         end
      end
   end

   // Address decode for writes; read-only registers accept and ignore
   always_comb begin
      wr_hit = 1'b1;
      if (aw_addr_r == ADDR_TSC) begin
         wr_hit = 1'b1;
      end else if (aw_addr_r == ADDR_CNT || aw_addr_r == ADDR_STATUS) begin
         wr_hit = 1'b1;
      end else if (aw_addr_r == ADDR_MOD_HI || aw_addr_r == ADDR_MOD_LO) begin
         wr_hit = 1'b1;
      end else if (aw_addr_r == ADDR_CH_CTL) begin
         wr_hit = 1'b1;
      end else if (aw_addr_r == ADDR_CHV_HI || aw_addr_r == ADDR_CHV_LO) begin
         wr_hit = 1'b1;
      end else begin
         wr_hit = 1'b0;
      end
   end

   // Byte lane 0 carries every register; a write without it does nothing
   assign wr_tsc    = wr_go && w_strb0_r && (aw_addr_r == ADDR_TSC);
   assign wr_mod_hi = wr_go && w_strb0_r && (aw_addr_r == ADDR_MOD_HI);
   assign wr_mod_lo = wr_go && w_strb0_r && (aw_addr_r == ADDR_MOD_LO);
   assign wr_chv_hi = wr_go && w_strb0_r && (aw_addr_r == ADDR_CHV_HI);
   assign wr_chv_lo = wr_go && w_strb0_r && (aw_addr_r == ADDR_CHV_LO);

   // Write response, held until taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (clk_en) begin
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ---------------- Control registers ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer_status_control_r <= TSC_RST;
         ch_mode_r              <= PCVB_CH_OFF;
      end else if (clk_en) begin
         if (wr_tsc) timer_status_control_r <= w_data_r[7:0];
         if (wr_go && w_strb0_r && aw_addr_r == ADDR_CH_CTL) ch_mode_r <= w_data_r[1:0];
      end
   end

   // Modulo half-write is dropped by a control write only in debug mode
   assign mod_clr = wr_tsc && background_debug_mode;

   pcvb_byte_pair #(.W(16)) u_mod_pair (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (clk_en),
      .wr_hi   (wr_mod_hi),
      .wr_lo   (wr_mod_lo),
      .wbyte   (w_data_r[7:0]),
      .clr     (mod_clr),
      .take    (mod_full),
      .word_r  (mod_buf),
      .half_r  (mod_half),
      .full_r  (mod_full)
   );

   // Modulo takes effect once the pair is complete
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         counter_modulo_word_r <= MOD_RST;
      end else if (clk_en && mod_full) begin
         counter_modulo_word_r <= mod_buf;
      end
   end

   // Any control write restarts channel value pairing
   pcvb_byte_pair #(.W(16)) u_chv_pair (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (clk_en),
      .wr_hi   (wr_chv_hi),
      .wr_lo   (wr_chv_lo),
      .wbyte   (w_data_r[7:0]),
      .clr     (wr_tsc),
      .take    (chv_take),
      .word_r  (chv_buf),
      .half_r  (chv_half),
      .full_r  (chv_full)
   );

   // Choose when a completed value moves into the active register
   always_comb begin
      chv_take = 1'b0;
      if (!chv_full) begin
         chv_take = 1'b0;
      end else if (clock_source_select == 2'b00) begin
         // Timer stopped: nothing to keep glitch-free
         chv_take = 1'b1;
      end else if (center_aligned_pwm || edge_aligned_pwm) begin
         chv_take = xfer_pt;
      end else if (ch_mode_r == PCVB_CH_OC) begin
         chv_take = tick;
      end else begin
         chv_take = clk_en;
      end
   end

   // Active compare value; changes only at the chosen point
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         channel_compare_word_r <= CHV_RST;
      end else if (clk_en && chv_take) begin
         channel_compare_word_r <= chv_buf;
      end
   end

   // ---------------- Counter ----------------
   // Up/down in center mode, wrapping up-count otherwise
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r <= 16'h0000;
         up_r  <= 1'b1;
      end else if (tick) begin
         if (!center_aligned_pwm) begin
            up_r  <= 1'b1;
            cnt_r <= (cnt_r >= top) ? 16'h0000 : cnt_r + 16'h0001;
         end else if (up_r) begin
            if (cnt_r >= top) begin
               up_r  <= 1'b0;
               cnt_r <= cnt_r - 16'h0001;
            end else begin
               cnt_r <= cnt_r + 16'h0001;
            end
         end else begin
            if (cnt_r == 16'h0000) begin
               up_r  <= 1'b1;
               cnt_r <= 16'h0001;
            end else begin
               cnt_r <= cnt_r - 16'h0001;
            end
         end
      end
   end

   // ---------------- Channel output ----------------
   // Center: active below the value, set on the down match, cleared on the up match;
   // value equal to modulo never leaves the active band
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_r <= 1'b0;
      end else if (clk_en) begin
         if (center_aligned_pwm) begin
            out_r <= (channel_compare_word_r == top)
                     || (cnt_r < channel_compare_word_r);
         end else if (edge_aligned_pwm) begin
            out_r <= (cnt_r < channel_compare_word_r);
         end else if (ch_mode_r == PCVB_CH_OC) begin
            if (tick && cnt_r == channel_compare_word_r) out_r <= !out_r;
         end else begin
            out_r <= 1'b0;
         end
      end
   end

   assign ch_out = out_r;

   // ---------------- AXI4-Lite read path ----------------
   // Frozen block takes no read address
   assign s_axi_arready = clk_en && !s_axi_rvalid;

   // Read mux; narrow registers sit in the low bits
   always_comb begin
      rd_hit = 1'b1;
      rd_val = 32'h0000_0000;
      if (s_axi_araddr == ADDR_TSC) begin
         rd_val[7:0] = timer_status_control_r;
      end else if (s_axi_araddr == ADDR_CNT) begin
         rd_val[15:0] = cnt_r;
      end else if (s_axi_araddr == ADDR_MOD_HI) begin
         rd_val[7:0] = counter_modulo_word_r[15:8];
      end else if (s_axi_araddr == ADDR_MOD_LO) begin
         rd_val[7:0] = counter_modulo_word_r[7:0];
      end else if (s_axi_araddr == ADDR_CH_CTL) begin
         rd_val[1:0] = ch_mode_r;
      end else if (s_axi_araddr == ADDR_CHV_HI) begin
         rd_val[7:0] = channel_compare_word_r[15:8];
      end else if (s_axi_araddr == ADDR_CHV_LO) begin
         rd_val[7:0] = channel_compare_word_r[7:0];
      end else if (s_axi_araddr == ADDR_STATUS) begin
         rd_val[ST_CHV_PEND] = chv_full;
         rd_val[ST_CHV_HALF] = chv_half;
         rd_val[ST_MOD_HALF] = mod_half;
         rd_val[ST_OUT]      = out_r;
         rd_val[ST_UP]       = up_r;
      end else begin
         rd_hit = 1'b0;
      end
   end

   // Read data registered; held until rready
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (clk_en) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : pcvb_channel

// File: tb/pcvb_channel_monitor.sv
// Checker on the bus handshake and channel pin of the PWM channel block
`timescale 1ns/1ps
module pcvb_channel_monitor
   import pcvb_pkg::*;
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        clk_en,
   input wire logic        background_debug_mode,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        ch_out
);
   // One clock domain, so clock and reset are given once
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // No new write accepted while a response waits
   property p_wr_busy;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_wr_busy: assert property (p_wr_busy) else $error("write taken during response");
   // No new read accepted while read data waits
   property p_ar_busy;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_ar_busy: assert property (p_ar_busy) else $error("read taken during data phase");
   // Response stands until taken
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
   // Read data stands until taken
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
   // Address and data taken together: response two edges later
   property p_wr_resp;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clk_en ##1 clk_en
         |=> s_axi_bvalid;
   endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("write response late");
   // Read answers at the next edge
   property p_rd_resp;
      s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid;
   endproperty
   a_rd_resp: assert property (p_rd_resp) else $error("read data late");
   // Past the map: error code and zero data
   property p_rd_err;
      s_axi_arvalid && s_axi_arready && clk_en && s_axi_araddr > 8'h1c
         |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
   endproperty
   a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
   // Halted counter: pin moves only after a register write
   property p_dbg_pin;
      $changed(ch_out) && $past(background_debug_mode, 1) && $past(background_debug_mode, 2)
         && $past(background_debug_mode, 3) |-> $past(s_axi_bvalid, 1) || $past(s_axi_bvalid, 2);
   endproperty
   a_dbg_pin: assert property (p_dbg_pin) else $error("pin moved while halted");
endmodule : pcvb_channel_monitor

bind pcvb_channel pcvb_channel_monitor u_mon (
   .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
   .background_debug_mode(background_debug_mode),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .ch_out(ch_out)
);

// File: tb/pcvb_pin_load.sv
// Load on the channel pin that totals the clocks spent high
`timescale 1ns/1ps
module pcvb_pin_load (
   input  wire logic aclk,
   input  wire logic pin,
   output int        high_cnt
);
   // Running total; the bench takes differences, so the phase of a window never matters
   initial high_cnt = 0;
   always @(posedge aclk) begin
      high_cnt <= high_cnt + int'(pin);
   end
endmodule : pcvb_pin_load

// File: tb/pcvb_channel_bench.sv
// Self-checking bench for the PWM channel block
`timescale 1ns/1ps
module pcvb_channel_bench;
   import pcvb_pkg::*;
   logic        aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, dbg = 1'b0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, d, c;
   logic [3:0]  wstrb = 4'h0;
   logic [1:0]  bresp, rresp, r;
   logic        awready, wready, bvalid, arready, rvalid, ch_out;
   int          error_cnt = 0, samples_checked = 0, hc, h0, i;
   // Center duty table: top 9 gives 18 states a period, windows of 10 periods
   logic [15:0] cv [4] = '{16'h0009, 16'h0008, 16'h0000, 16'h0003};
   int          ch [4] = '{180, 150, 0, 50};
   always #2.5 aclk = ~aclk;
   pcvb_channel u_dut (
      .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .background_debug_mode(dbg),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .ch_out(ch_out)
   );
   pcvb_pin_load u_pin (.aclk(aclk), .pin(ch_out), .high_cnt(hc));
   // Verdict and end of run
   task automatic final_report;
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // A spent wait bound ends the run
   task automatic tmo(input int n);
      if (n >= 2000) begin
         error_cnt++;
         $display("[FAIL] %0t bus wait ran out", $time);
         final_report();
      end
   endtask : tmo
   // Write: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [3:0] s = 4'h1);
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, v};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 2000; n++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      tmo(n);
      r = bresp;
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 2000; n++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      tmo(n);
      q = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd
   // Byte pair, high first; low byte sits one word above
   task automatic w16(input logic [7:0] a, input logic [15:0] v);
      wr(a, v[15:8]);
      wr(a + 8'h04, v[7:0]);
   endtask : w16
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      rd(a, d);
      chk(d, e);
   endtask : rc
   task automatic st(input int b, input logic e);
      rd(ADDR_STATUS, d);
      chk({31'h0, d[b]}, {31'h0, e});
   endtask : st
   // High clocks over a window of whole periods
   task automatic msr(input int n, input int e);
      h0 = hc;
      repeat (n) @(posedge aclk);
      chk(32'(hc - h0), 32'(e));
   endtask : msr
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rc(ADDR_TSC, 32'h0);
      rc(ADDR_CH_CTL, 32'h0);
      rc(8'h40, 32'h0);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      wr(8'h40, 8'h01);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      // Strobe off: write ignored
      wr(ADDR_TSC, 8'h08, 4'h0);
      rc(ADDR_TSC, 32'h0);
      wr(ADDR_TSC, 8'h08);
      w16(ADDR_MOD_HI, 16'h0009);
      wr(ADDR_CH_CTL, 8'h02);
      // Halted counter keeps a new value pending
      dbg <= 1'b1;
      rd(ADDR_CNT, c);
      rc(ADDR_CNT, c);
      w16(ADDR_CHV_HI, 16'h0004);
      rc(ADDR_CHV_LO, 32'h0);
      st(ST_CHV_PEND, 1'b1);
      dbg <= 1'b0;
      repeat (25) @(posedge aclk);
      rc(ADDR_CHV_LO, 32'h4);
      msr(100, 40);
      // Control write drops half a channel value pair, and half a modulo pair only in debug mode
      wr(ADDR_CHV_HI, 8'h00);
      st(ST_CHV_HALF, 1'b1);
      wr(ADDR_TSC, 8'h08);
      st(ST_CHV_HALF, 1'b0);
      wr(ADDR_MOD_HI, 8'h00);
      wr(ADDR_TSC, 8'h08);
      st(ST_MOD_HALF, 1'b1);
      dbg <= 1'b1;
      wr(ADDR_TSC, 8'h08);
      st(ST_MOD_HALF, 1'b0);
      dbg <= 1'b0;
      rc(ADDR_MOD_LO, 32'h9);
      // Center mode duty table
      wr(ADDR_TSC, 8'h28);
      for (i = 0; i < 4; i++) begin
         w16(ADDR_CHV_HI, cv[i]);
         repeat (40) @(posedge aclk);
         msr(180, ch[i]);
      end
      dbg <= 1'b1;
      w16(ADDR_CHV_HI, 16'h0000);
      rc(ADDR_CHV_LO, 32'h3);
      dbg <= 1'b0;
      // Compare mode loads at the next step and toggles once a period
      wr(ADDR_TSC, 8'h08);
      wr(ADDR_CH_CTL, 8'h01);
      w16(ADDR_CHV_HI, 16'h0005);
      rc(ADDR_CHV_LO, 32'h5);
      msr(100, 50);
      clk_en <= 1'b0;
      @(posedge aclk);
      msr(20, ch_out ? 20 : 0);
      clk_en <= 1'b1;
      // Free-running: load waits for the top of the count
      wr(ADDR_CH_CTL, 8'h02);
      w16(ADDR_MOD_HI, 16'h0000);
      w16(ADDR_CHV_HI, 16'h0123);
      d = 32'h0;
      for (i = 0; i < 40000 && !(d >= 32'hff00 && d < 32'hff80); i++) begin
         rd(ADDR_CNT, d);
      end
      // Counter never reached the top window: count it as a spent wait
      if (i >= 40000) tmo(2000);
      rc(ADDR_CHV_LO, 32'h5);
      repeat (300) @(posedge aclk);
      rc(ADDR_CHV_HI, 32'h1);
      rc(ADDR_CHV_LO, 32'h23);
      final_report();
   end
endmodule : pcvb_channel_bench
